/* rtl/srxpc_top.v */
// serial receiver phy control register bank with per-lane error tallies
// assumes an avalon-mm master on i_clock and lane error strobes from
// pattern checkers on the same clock; lane rate code comes from logic
// elsewhere on this clock, so none of these inputs is synchronised
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "srxpc_consts.vh"

module srxpc_top #(
  parameter LANES = 16               // number of receive lanes
) (
  input  wire             i_clock,            // 125 MHz system clock
  input  wire             i_rstn,             // synchronous reset, active low
  input  wire             i_clk_en,           // freezes all state while low
  // avalon-mm slave
  input  wire [11:0]      i_avs_address,      // byte address
  input  wire             i_avs_read,         // read request
  input  wire             i_avs_write,        // write request
  input  wire [31:0]      i_avs_writedata,    // write data
  input  wire [3:0]       i_avs_byteenable,   // byte lanes
  output wire [31:0]      o_avs_readdata,     // read data
  output wire             o_avs_waitrequest,  // stall, high while busy
  // lane side
  input  wire [LANES-1:0] i_lane_bit_error,   // one pulse per detected error
  input  wire [1:0]       i_lane_bit_rate,    // lane rate code
  // recovery loop controls
  output wire [2:0]       o_cdr_setting,      // raw recovery code
  output wire             o_cdr_second_order, // second-order loop
  output wire [3:0]       o_cdr_vote_threshold, // vote threshold
  output wire [10:0]      o_cdr_settle_ui,    // settling time in ui
  output wire             o_offset_cal_enable, // offset calibration on
  output wire             o_signal_loss_detect_enable, // loss detector on
  // equalizer controls
  output wire [1:0]       o_equalizer_select, // raw equalizer mode
  output wire             o_eq_flat_max_gain, // equalizer off, flat
  output wire             o_eq_enable,        // equalizer running
  output wire             o_eq_precursor_run, // precursor analysis
  output wire             o_eq_postcursor_run, // postcursor analysis
  output wire             o_eq_use_manual_level, // use manual strengths
  output wire             o_adapt_freeze,     // hold adaptation loop
  output wire [4:0]       o_zero_freq_code,   // zero frequency in effect
  output wire             o_error_test_arm    // tallies counting
);

  // ---------------- register storage ----------------
  reg  [7:0]  arm_q;            // error test arm register
  reg         arm_prev_q;       // arm bit delayed, for rise detect
  reg  [7:0]  phy_ctrl_q;       // phy receiver control
  reg  [7:0]  eqctl_q;          // equalizer control
  reg  [7:0]  zero_set_q;       // equalizer zero frequency setting
  reg         restart_q;        // one-cycle tally restart pulse
  reg         restart_d;        // next restart pulse

  // ---------------- bus handshake ----------------
  reg         wait_q;           // waitrequest register
  reg         wait_d;           // next waitrequest
  reg  [31:0] rdata_q;          // read data register
  reg  [31:0] rdata_d;          // next read data
  wire        req;              // read or write present
  wire [9:0]  idx;              // register index from byte address
  wire        commit;           // write takes effect this edge
  wire        wr_lane0;         // write enables byte lane 0

  // ---------------- decoded control outputs ----------------
  reg  [2:0]  cdr_q;            // registered recovery code
  reg         second_q;         // registered loop order
  reg  [3:0]  vote_q;           // registered vote threshold
  reg  [10:0] settle_q;         // registered settling time
  reg         second_d;         // decoded loop order
  reg  [3:0]  vote_d;           // decoded vote threshold
  reg  [10:0] settle_d;         // decoded settling time
  reg         ocal_q;           // registered offset calibration enable
  reg         loss_q;           // registered loss detect enable
  reg  [1:0]  eqsel_q;          // registered equalizer mode
  reg         flat_q;           // registered flat mode
  reg         eqen_q;           // registered equalizer enable
  reg         pre_q;            // registered precursor analysis
  reg         post_q;           // registered postcursor analysis
  reg         manual_q;         // registered manual level use
  reg         freeze_q;         // registered adaptation hold
  reg  [4:0]  zero_q;           // registered zero frequency code
  reg  [4:0]  zero_rate_d;      // zero code derived from rate
  reg  [4:0]  zero_d;           // zero code in effect
  reg         armed_q;          // registered arm state for output

  // ---------------- lane tallies ----------------
  wire [8*LANES-1:0] tally_flat; // all tallies packed, lane 0 lowest
  wire               armed;      // arm bit from register

  assign req      = i_avs_read | i_avs_write;
  assign idx      = i_avs_address[11:2];
  assign commit   = i_avs_write & ~wait_q;
  assign wr_lane0 = i_avs_byteenable[0];
  assign armed    = arm_q[`SRXPC_ARM_BIT];

  // waitrequest drops for exactly one cycle per request, one cycle after it
  // appears; the master samples it low at the following edge and releases
  always @* begin
    wait_d = 1'b1;
    if (req && wait_q) begin
      wait_d = 1'b0;              // answer next cycle
    end
  end

  // read mux; unmapped indices read as zero
  always @* begin
    rdata_d = rdata_q;
    if (i_avs_read && wait_q) begin
      rdata_d = 32'h0000_0000;
      if (idx == `SRXPC_IDX_ARM) begin
        rdata_d[7:0] = arm_q;
      end else if (idx == `SRXPC_IDX_PHY_CTRL) begin
        rdata_d[7:0] = phy_ctrl_q;
      end else if (idx == `SRXPC_IDX_EQCTL) begin
        rdata_d[7:0] = eqctl_q;
      end else if (idx == `SRXPC_IDX_ZERO_SET) begin
        rdata_d[7:0] = zero_set_q;
      end else if ((idx >= `SRXPC_IDX_TALLY_BASE) &&
                   (idx < (`SRXPC_IDX_TALLY_BASE + LANES[9:0]))) begin
        // reading a tally leaves counting untouched [R2] [R17]
        rdata_d[7:0] = tally_flat[8*(idx-`SRXPC_IDX_TALLY_BASE) +: 8];
      end
    end
  end

  // tally restart fires on the rising edge of the arm bit
  always @* begin
    restart_d = armed & ~arm_prev_q;  // [R4]
  end

  // bus handshake registers
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // software-written registers; writes land at the edge waitrequest is low
  // and tally addresses are read only, so writes to them are dropped
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      arm_q      <= `SRXPC_RST_ARM;
      phy_ctrl_q <= `SRXPC_RST_PHY_CTRL;  // recovery code 100b [R6] [R9] [R10]
      eqctl_q    <= `SRXPC_RST_EQCTL;     // select 00 [R11]
      zero_set_q <= `SRXPC_RST_ZERO_SET;  // [R15]
      arm_prev_q <= 1'b0;
      restart_q  <= 1'b0;
    end else if (i_clk_en) begin
      arm_prev_q <= armed;
      restart_q  <= restart_d;
      if (commit && wr_lane0) begin
        if (idx == `SRXPC_IDX_ARM) begin
          arm_q <= i_avs_writedata[7:0];
        end
        if (idx == `SRXPC_IDX_PHY_CTRL) begin
          phy_ctrl_q <= i_avs_writedata[7:0];
        end
        if (idx == `SRXPC_IDX_EQCTL) begin
          eqctl_q <= i_avs_writedata[7:0];
        end
        if (idx == `SRXPC_IDX_ZERO_SET) begin
          zero_set_q <= i_avs_writedata[7:0];  // [R15]
        end
      end
    end
  end

  // recovery code decode: order, vote threshold and settling time
  always @* begin
    second_d = 1'b0;
    vote_d   = `SRXPC_VOTE_15;
    settle_d = `SRXPC_SETTLE_SHORT;
    case (phy_ctrl_q[`SRXPC_PHY_CDR_MSB:`SRXPC_PHY_CDR_LSB])
      3'h0: begin
        second_d = 1'b1;          // second order [R7]
        vote_d   = `SRXPC_VOTE_15;
      end
      3'h1: begin
        second_d = 1'b1;
        vote_d   = `SRXPC_VOTE_7;
      end
      3'h2: begin
        second_d = 1'b1;
        vote_d   = `SRXPC_VOTE_3;
      end
      3'h3: begin
        second_d = 1'b1;
        vote_d   = `SRXPC_VOTE_1;
      end
      3'h4: begin
        vote_d   = `SRXPC_VOTE_15; // first order from here on [R7]
      end
      3'h5: begin
        vote_d   = `SRXPC_VOTE_3;
      end
      3'h6: begin
        vote_d   = `SRXPC_VOTE_1;
      end
      3'h7: begin
        vote_d   = `SRXPC_VOTE_7;
        settle_d = `SRXPC_SETTLE_LONG; // slow settling code [R7]
      end
      default: begin
        vote_d   = `SRXPC_VOTE_15;
      end
    endcase
  end

  // zero frequency: override register or rate-derived default
  always @* begin
    case (i_lane_bit_rate)
      2'h0: zero_rate_d = `SRXPC_ZERO_RATE_FULL;
      2'h1: zero_rate_d = `SRXPC_ZERO_RATE_FULL;
      2'h2: zero_rate_d = `SRXPC_ZERO_RATE_QTR;
      2'h3: zero_rate_d = `SRXPC_ZERO_RATE_EIGHTH;
      default: zero_rate_d = `SRXPC_ZERO_RATE_FULL;
    endcase
    if (eqctl_q[`SRXPC_EQ_ZOVR_BIT]) begin
      zero_d = zero_set_q[`SRXPC_ZERO_MSB:`SRXPC_ZERO_LSB];  // [R13] [R16]
    end else begin
      zero_d = zero_rate_d;                                   // [R13]
    end
  end

  // registered control outputs, one cycle behind the registers
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      cdr_q    <= 3'h4;
      second_q <= 1'b0;
      vote_q   <= `SRXPC_VOTE_15;
      settle_q <= `SRXPC_SETTLE_SHORT;
      ocal_q   <= 1'b1;
      loss_q   <= 1'b1;
      eqsel_q  <= `SRXPC_EQSEL_FLAT;
      flat_q   <= 1'b1;
      eqen_q   <= 1'b0;
      pre_q    <= 1'b0;
      post_q   <= 1'b0;
      manual_q <= 1'b0;
      freeze_q <= 1'b0;
      zero_q   <= `SRXPC_ZERO_RATE_FULL;
      armed_q  <= 1'b0;
    end else if (i_clk_en) begin
      cdr_q    <= phy_ctrl_q[`SRXPC_PHY_CDR_MSB:`SRXPC_PHY_CDR_LSB];  // [R6]
      second_q <= second_d;                                          // [R7]
      vote_q   <= vote_d;
      settle_q <= settle_d;
      ocal_q   <= phy_ctrl_q[`SRXPC_PHY_OCAL_BIT];                    // [R9]
      loss_q   <= phy_ctrl_q[`SRXPC_PHY_LOSS_BIT];                    // [R10]
      eqsel_q  <= eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB];       // [R11]
      flat_q   <= (eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB] ==
                   `SRXPC_EQSEL_FLAT);                               // [R11]
      eqen_q   <= (eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB] ==
                   `SRXPC_EQSEL_ADAPT);
      pre_q    <= (eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB] ==
                   `SRXPC_EQSEL_PRE);
      post_q   <= (eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB] ==
                   `SRXPC_EQSEL_POST);
      // manual strengths only in the enabled mode with override [R12]
      manual_q <= (eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB] ==
                   `SRXPC_EQSEL_ADAPT) && eqctl_q[`SRXPC_EQ_LOVR_BIT];
      // hold acts only in fully adaptive operation [R14]
      freeze_q <= (eqctl_q[`SRXPC_EQ_SEL_MSB:`SRXPC_EQ_SEL_LSB] ==
                   `SRXPC_EQSEL_ADAPT) && !eqctl_q[`SRXPC_EQ_LOVR_BIT] &&
                  eqctl_q[`SRXPC_EQ_FREEZE_BIT];
      zero_q   <= zero_d;
      armed_q  <= armed;
    end
  end

  // one saturating tally per lane; spare or disabled lanes still count
  // whatever their checker reports, which software must ignore [R3]
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      srxpc_tally u_tally (
        .i_clock     (i_clock),
        .i_rstn      (i_rstn),
        .i_clk_en    (i_clk_en),
        .i_restart   (restart_q),
        .i_armed     (armed),           // counts only while armed [R17]
        .i_bit_error (i_lane_bit_error[g]),
        .o_count     (tally_flat[8*g +: 8])  // lane 0 lowest [R2]
      );
    end
  endgenerate

  // output drive, all straight from flops
  assign o_avs_readdata              = rdata_q;
  assign o_avs_waitrequest           = wait_q;
  assign o_cdr_setting               = cdr_q;
  assign o_cdr_second_order          = second_q;
  assign o_cdr_vote_threshold        = vote_q;
  assign o_cdr_settle_ui             = settle_q;
  assign o_offset_cal_enable         = ocal_q;
  assign o_signal_loss_detect_enable = loss_q;
  assign o_equalizer_select          = eqsel_q;
  assign o_eq_flat_max_gain          = flat_q;
  assign o_eq_enable                 = eqen_q;
  assign o_eq_precursor_run          = pre_q;
  assign o_eq_postcursor_run         = post_q;
  assign o_eq_use_manual_level       = manual_q;
  assign o_adapt_freeze              = freeze_q;
  assign o_zero_freq_code            = zero_q;
  assign o_error_test_arm            = armed_q;

endmodule
`default_nettype wire

/* rtl/srxpc_consts.vh */
// constants for the serial receiver phy control register bank
// assumes inclusion by srxpc_top, srxpc_tally and the self-checking bench; holds definitions only
//
// Functional notes
// R1: 8-bit error tally per lane, saturating at 255
// R2: tallies at consecutive indices, lane 0 lowest
// R3: disabled or spare lane tallies read undefined
// R4: software clears tallies by rearming the arm bit
// R5: software changes phy control only while link disabled
// R6: recovery setting field bits 6-4, reset 100b
// R7: codes select loop order, vote threshold, settling
// R8: software uses second-order codes only without shared clock
// R9: bit 1 enables offset calibration, all lanes
// R10: bit 0 enables signal loss detect, all lanes
// R11: 2-bit equalizer select, reset 00, four modes
// R12: select 1 plus override uses manual levels
// R13: zero override picks setting, else rate derived
// R14: adaptive mode plus freeze holds adaptation loop; the code holds only with level override off
// R15: zero setting register at 01C3h, reset zero
// R16: zero setting bits 4-0, 1Fh highest frequency
// R17: tallies count only while armed, reads harmless
`ifndef SRXPC_CONSTS_VH
`define SRXPC_CONSTS_VH

// register indices; byte address is four times the index
`define SRXPC_IDX_ARM          10'h1a0
`define SRXPC_IDX_TALLY_BASE   10'h1b0
`define SRXPC_IDX_PHY_CTRL     10'h1c1
`define SRXPC_IDX_EQCTL        10'h1c2
`define SRXPC_IDX_ZERO_SET     10'h1c3

// reset values
`define SRXPC_RST_ARM          8'h00
`define SRXPC_RST_PHY_CTRL     8'h43
`define SRXPC_RST_EQCTL        8'h00
`define SRXPC_RST_ZERO_SET     8'h00

// field positions
`define SRXPC_ARM_BIT          0
`define SRXPC_PHY_LOSS_BIT     0
`define SRXPC_PHY_OCAL_BIT     1
`define SRXPC_PHY_CDR_LSB      4
`define SRXPC_PHY_CDR_MSB      6
`define SRXPC_EQ_SEL_LSB       0
`define SRXPC_EQ_SEL_MSB       1
`define SRXPC_EQ_FREEZE_BIT    2
`define SRXPC_EQ_ZOVR_BIT      3
`define SRXPC_EQ_LOVR_BIT      4
`define SRXPC_ZERO_LSB         0
`define SRXPC_ZERO_MSB         4

// equalizer select codes
`define SRXPC_EQSEL_FLAT       2'h0
`define SRXPC_EQSEL_ADAPT      2'h1
`define SRXPC_EQSEL_PRE        2'h2
`define SRXPC_EQSEL_POST       2'h3

// recovery loop vote thresholds per code
`define SRXPC_VOTE_15          4'hf
`define SRXPC_VOTE_7           4'h7
`define SRXPC_VOTE_3           4'h3
`define SRXPC_VOTE_1           4'h1
// settling time in unit intervals
`define SRXPC_SETTLE_SHORT     11'h024
`define SRXPC_SETTLE_LONG      11'h5f4

// zero frequency codes derived from the lane rate setting
`define SRXPC_ZERO_RATE_FULL   5'h1f
`define SRXPC_ZERO_RATE_QTR    5'h1b
`define SRXPC_ZERO_RATE_EIGHTH 5'h08

// tally limits
`define SRXPC_TALLY_MAX        8'hff
`define SRXPC_TALLY_ZERO       8'h00

`endif

/* rtl/srxpc_tally.v */
// one saturating error tally for a single lane
// assumes the error strobe is produced on the same clock by the pattern checker
`timescale 1ns/1ps
`default_nettype none
`include "srxpc_consts.vh"

module srxpc_tally (
  input  wire       i_clock,      // system clock
  input  wire       i_rstn,       // synchronous reset, active low
  input  wire       i_clk_en,     // freezes the tally while low
  input  wire       i_restart,    // one-cycle pulse: clear to zero
  input  wire       i_armed,      // counting allowed
  input  wire       i_bit_error,  // one detected bit error this cycle
  output wire [7:0] o_count       // current tally
);

  reg [7:0] count_q;  // tally value
  reg [7:0] count_d;  // next tally value

  // restart wins, then count with saturation
  always @* begin
    count_d = count_q;
    if (i_restart) begin
      count_d = `SRXPC_TALLY_ZERO;  // [R4]
    end else if (i_armed && i_bit_error && (count_q != `SRXPC_TALLY_MAX)) begin
      count_d = count_q + 8'h01;    // stops at 255 [R1] [R17]
    end
  end

  // tally register, frozen by clock enable
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      count_q <= `SRXPC_TALLY_ZERO;
    end else if (i_clk_en) begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule
`default_nettype wire

/* tb/srxpc_props.sv */
// concurrent checks on the ports of the phy control register bank
// assumes one clock and a synchronous active-low reset; bound to srxpc_top
`timescale 1ns/1ps
`default_nettype none
module srxpc_props #(
  parameter LANES = 16
) (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_clk_en,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [2:0]  o_cdr_setting,
  input wire logic        o_cdr_second_order,
  input wire logic [3:0]  o_cdr_vote_threshold,
  input wire logic [10:0] o_cdr_settle_ui,
  input wire logic        o_offset_cal_enable,
  input wire logic        o_signal_loss_detect_enable,
  input wire logic [1:0]  o_equalizer_select,
  input wire logic        o_eq_flat_max_gain,
  input wire logic        o_eq_enable,
  input wire logic        o_eq_precursor_run,
  input wire logic        o_eq_postcursor_run,
  input wire logic        o_eq_use_manual_level,
  input wire logic        o_adapt_freeze,
  input wire logic        o_error_test_arm
);
  // vote thresholds by recovery code, code 0 in the low nibble
  localparam logic [31:0] VOTE_TBL = 32'h713f137f;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // a taken request is answered after exactly one wait cycle
  answer_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en
    |=> !o_avs_waitrequest) else $error("request not answered in one cycle");
  wait_pulse_a: assert property (!o_avs_waitrequest && i_clk_en |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  rd_upper_a: assert property (o_avs_readdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  reset_val_a: assert property ($rose(i_rstn) |-> o_cdr_setting == 3'h4 && o_offset_cal_enable
    && o_signal_loss_detect_enable && o_eq_flat_max_gain && !o_error_test_arm)
    else $error("control outputs wrong after reset");
  // decoded recovery outputs follow the code once it has settled
  order_map_a: assert property ($stable(o_cdr_setting) |-> o_cdr_second_order == (o_cdr_setting < 3'h4))
    else $error("loop order does not match recovery code");
  vote_map_a: assert property ($stable(o_cdr_setting)
    |-> o_cdr_vote_threshold == VOTE_TBL[{o_cdr_setting, 2'b00} +: 4]) else $error("vote threshold wrong");
  settle_map_a: assert property ($stable(o_cdr_setting)
    |-> o_cdr_settle_ui == ((o_cdr_setting == 3'h7) ? 11'h5f4 : 11'h024)) else $error("settling wrong");
  eq_onehot_a: assert property ($stable(o_equalizer_select) |-> {o_eq_postcursor_run,
    o_eq_precursor_run, o_eq_enable, o_eq_flat_max_gain} == (4'h1 << o_equalizer_select))
    else $error("equalizer mode decode wrong");
  manual_sel_a: assert property ($stable(o_equalizer_select) && o_eq_use_manual_level
    |-> o_equalizer_select == 2'h1 && !o_adapt_freeze) else $error("manual level outside mode 1");
  freeze_sel_a: assert property ($stable(o_equalizer_select) && o_adapt_freeze
    |-> o_equalizer_select == 2'h1) else $error("freeze outside adaptive mode");
  // main scenarios reached
  cover property (o_cdr_settle_ui == 11'h5f4);
  cover property (o_adapt_freeze);
  cover property (o_eq_use_manual_level);
  cover property (i_avs_write && !o_avs_waitrequest);
endmodule
bind srxpc_top srxpc_props #(.LANES(LANES)) u_props (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_cdr_setting(o_cdr_setting),
  .o_cdr_second_order(o_cdr_second_order), .o_cdr_vote_threshold(o_cdr_vote_threshold),
  .o_cdr_settle_ui(o_cdr_settle_ui), .o_offset_cal_enable(o_offset_cal_enable),
  .o_signal_loss_detect_enable(o_signal_loss_detect_enable),
  .o_equalizer_select(o_equalizer_select), .o_eq_flat_max_gain(o_eq_flat_max_gain),
  .o_eq_enable(o_eq_enable), .o_eq_precursor_run(o_eq_precursor_run),
  .o_eq_postcursor_run(o_eq_postcursor_run), .o_eq_use_manual_level(o_eq_use_manual_level),
  .o_adapt_freeze(o_adapt_freeze), .o_error_test_arm(o_error_test_arm));
`default_nettype wire

/* tb/srxpc_lane_src.sv */
// lane-side source of bit error pulses, standing in for the pattern checkers
// assumes loads arrive on the system clock; pulses prompt or every other cycle
`timescale 1ns/1ps
`default_nettype none
module srxpc_lane_src #(
  parameter LANES = 16
) (
  input  wire logic             i_clock,     // system clock
  input  wire logic             i_load,      // take a new burst
  input  wire logic [LANES-1:0] i_mask,      // lanes that see errors
  input  wire logic [9:0]       i_count,     // pulses per lane
  input  wire logic             i_slow,      // gap between pulses
  output logic      [LANES-1:0] o_bit_error, // error pulses
  output wire logic             o_busy       // burst still running
);
  logic [9:0]       left_q = 10'h0;  // pulses still to send
  logic [LANES-1:0] mask_q = '0;     // lanes of this burst
  logic             slow_q = 1'b0;   // slow pacing chosen
  logic             gap_q  = 1'b0;   // idle cycle pending
  // one pulse per cycle, or one every second cycle when slow
  always @(posedge i_clock) begin
    if (i_load) begin
      left_q      <= i_count;
      mask_q      <= i_mask;
      slow_q      <= i_slow;
      o_bit_error <= '0;
    end else if (left_q != 10'h0 && !gap_q) begin
      o_bit_error <= mask_q;
      left_q      <= left_q - 10'h1;
      gap_q       <= slow_q;
    end else begin
      o_bit_error <= '0;
      gap_q       <= 1'b0;
    end
  end
  assign o_busy = (left_q != 10'h0) || (o_bit_error != '0);
endmodule
`default_nettype wire

/* tb/tb_serdes_rx_phy_control.sv */
// self-checking bench for the phy control register bank
// assumes rtl/ on the include path and the lane error source model
`timescale 1ns/1ps
`default_nettype none
`include "srxpc_consts.vh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_serdes_rx_phy_control;
  localparam LANES = 16;
  localparam logic [31:0] VOTE_TBL = 32'h713f137f; // thresholds by code
  logic i_clock = 1'b0, i_rstn = 1'b0, i_clk_en = 1'b1, rd = 1'b0, wr_q = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0, q;
  logic [3:0] be = 4'h1;
  logic [1:0] rate = 2'h0;
  logic ld = 1'b0, slow = 1'b0;
  logic [LANES-1:0] mask = '0;
  logic [9:0] cnt = 10'h0;
  wire [31:0] rdata;
  wire wait_q, sec, ocal, loss, flat, eqen, pre, post, man, frz, arm, busy;
  wire [LANES-1:0] err;
  wire [2:0] cdr;
  wire [3:0] vote;
  wire [10:0] settle;
  wire [1:0] eqsel;
  wire [4:0] zcode;
  int n_errors = 0, checks = 0, cyc = 0;
  srxpc_top #(.LANES(LANES)) DUT (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr_q), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_q), .i_lane_bit_error(err),
    .i_lane_bit_rate(rate), .o_cdr_setting(cdr), .o_cdr_second_order(sec),
    .o_cdr_vote_threshold(vote), .o_cdr_settle_ui(settle), .o_offset_cal_enable(ocal),
    .o_signal_loss_detect_enable(loss), .o_equalizer_select(eqsel),
    .o_eq_flat_max_gain(flat), .o_eq_enable(eqen), .o_eq_precursor_run(pre),
    .o_eq_postcursor_run(post), .o_eq_use_manual_level(man), .o_adapt_freeze(frz),
    .o_zero_freq_code(zcode), .o_error_test_arm(arm));
  srxpc_lane_src #(.LANES(LANES)) u_src (.i_clock(i_clock), .i_load(ld), .i_mask(mask),
    .i_count(cnt), .i_slow(slow), .o_bit_error(err), .o_busy(busy));
  initial forever #4 i_clock = ~i_clock;
  // verdict and end of run
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] b);
    @(posedge i_clock);
    adr <= {idx, 2'b00};
    rd <= !w;
    wr_q <= w;
    wdat <= {24'h0, d};
    be <= b;
    do @(posedge i_clock); while (wait_q !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr_q <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] ex, input string nm);
    bus(1'b0, idx, 8'h0, 4'h1);
    `CHK(nm, {24'h0, ex}, q)
  endtask
  task automatic settle_wait;
    repeat (3) @(posedge i_clock);
  endtask
  // start an error burst on the lane model
  task automatic go(input logic [LANES-1:0] m, input logic [9:0] n, input logic s);
    @(posedge i_clock);
    ld <= 1'b1; mask <= m; cnt <= n; slow <= s;
    @(posedge i_clock);
    ld <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic idle;
    while (busy) @(posedge i_clock);
  endtask
  task automatic t_reset;
    rdc(`SRXPC_IDX_PHY_CTRL, 8'h43, "phy_ctrl");
    rdc(`SRXPC_IDX_EQCTL, 8'h00, "eqctl");
    rdc(`SRXPC_IDX_ZERO_SET, 8'h00, "zero_set");
    rdc(10'h1ff, 8'h00, "unmapped");
    `CHK("cdr", 3'h4, cdr)
    `CHK("flags", 8'he0, {ocal, loss, flat, eqen, pre, post, man, frz})
  endtask
  // every recovery code; link stays disabled while phy control changes
  task automatic t_cdr;
    for (int c = 0; c < 8; c++) begin
      wr(`SRXPC_IDX_PHY_CTRL, {1'b0, c[2:0], 4'h3});
      settle_wait();
      `CHK("order", (c < 4), sec)
      `CHK("vote", VOTE_TBL[4*c +: 4], vote)
      `CHK("settle", (c == 7) ? 11'h5f4 : 11'h024, settle)
    end
    wr(`SRXPC_IDX_PHY_CTRL, 8'hc0);
    rdc(`SRXPC_IDX_PHY_CTRL, 8'hc0, "phy_rb");
    settle_wait();
    `CHK("ocal_loss", 2'b00, {ocal, loss})
    wr(`SRXPC_IDX_PHY_CTRL, 8'h43);
  endtask
  // all modes, level override off and on, freeze set
  task automatic t_eq;
    for (int m = 0; m < 8; m++) begin
      wr(`SRXPC_IDX_EQCTL, {3'h0, m[2], 2'b01, m[1:0]});
      settle_wait();
      `CHK("eqsel", m[1:0], eqsel)
      `CHK("onehot", 4'h1 << m[1:0], {post, pre, eqen, flat})
      `CHK("manual", (m[1:0] == 2'h1) && m[2], man)
      `CHK("freeze", (m[1:0] == 2'h1) && !m[2], frz)
    end
  endtask
  task automatic t_zero;
    wr(`SRXPC_IDX_ZERO_SET, 8'he5);
    bus(1'b1, `SRXPC_IDX_ZERO_SET, 8'h1f, 4'h0);
    rdc(`SRXPC_IDX_ZERO_SET, 8'he5, "zero_rb");
    wr(`SRXPC_IDX_EQCTL, 8'h00);
    for (int r = 0; r < 4; r++) begin
      rate <= r[1:0];
      settle_wait();
      `CHK("zrate", (r < 2) ? 5'h1f : (r == 2) ? 5'h1b : 5'h08, zcode)
    end
    wr(`SRXPC_IDX_EQCTL, 8'h08);
    settle_wait();
    `CHK("zovr", 5'h05, zcode)
  endtask
  // all lanes enabled, so every tally is defined
  task automatic t_tally;
    wr(`SRXPC_IDX_ARM, 8'h01);
    repeat (4) @(posedge i_clock);
    go(16'h8001, 10'd300, 1'b0);
    idle();
    go(16'h0020, 10'd3, 1'b1);
    idle();
    rdc(`SRXPC_IDX_TALLY_BASE, 8'hff, "lane0");
    rdc(`SRXPC_IDX_TALLY_BASE + 10'd15, 8'hff, "lane15");
    wr(`SRXPC_IDX_TALLY_BASE + 10'd5, 8'h55);
    rdc(`SRXPC_IDX_TALLY_BASE + 10'd5, 8'h03, "lane5");
    rdc(`SRXPC_IDX_TALLY_BASE + 10'd1, 8'h00, "lane1");
    go(16'h0004, 10'd40, 1'b1);
    bus(1'b0, `SRXPC_IDX_TALLY_BASE + 10'd2, 8'h0, 4'h1);
    bus(1'b0, `SRXPC_IDX_TALLY_BASE + 10'd2, 8'h0, 4'h1);
    idle();
    rdc(`SRXPC_IDX_TALLY_BASE + 10'd2, 8'd40, "lane2");
    wr(`SRXPC_IDX_ARM, 8'h00);
    go(16'h0008, 10'd5, 1'b0);
    idle();
    rdc(`SRXPC_IDX_TALLY_BASE + 10'd3, 8'h00, "lane3");
    wr(`SRXPC_IDX_ARM, 8'h01);
    repeat (4) @(posedge i_clock);
    rdc(`SRXPC_IDX_TALLY_BASE, 8'h00, "cleared");
    `CHK("arm", 1'b1, arm)
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_reset();
    t_cdr();
    t_eq();
    t_zero();
    t_tally();
    wrap_up();
  end
endmodule
`default_nettype wire
